// file: include/cpc_defines.svh
/*
  Register offsets, field positions, reset values and mode codes of the
  capture/compare unit. Assumes inclusion by bare name from include/.
*/
`ifndef CPC_DEFINES_SVH
`define CPC_DEFINES_SVH

`define CPC_ADDR_CONTROL    4'h0
`define CPC_ADDR_VALUE_LO   4'h1
`define CPC_ADDR_VALUE_HI   4'h2
`define CPC_ADDR_STATUS     4'h3
`define CPC_ADDR_MASK       4'h4
`define CPC_ADDR_TIMER_CFG  4'h5
`define CPC_ADDR_COUNT_LO   4'h6
`define CPC_ADDR_COUNT_HI   4'h7

`define CPC_CONTROL_RST     8'h00
`define CPC_MODE_LSB        0
`define CPC_MODE_MSB        3

`define CPC_MODE_OFF        4'h0
`define CPC_MODE_CAP_FALL   4'h4
`define CPC_MODE_CAP_RISE   4'h5
`define CPC_MODE_CAP_RISE4  4'h6
`define CPC_MODE_CAP_RISE16 4'h7
`define CPC_MODE_CMP_SET    4'h8
`define CPC_MODE_CMP_CLR    4'h9
`define CPC_MODE_CMP_SWI    4'ha
`define CPC_MODE_CMP_SPEC   4'hb
`define CPC_MODE_CMP_TOG    4'h2

`define CPC_ST_EVENT        0
`define CPC_ST_TRIG         1

`define CPC_TCFG_RUN        0
`define CPC_TCFG_EXT        1
`define CPC_TCFG_ADC_EN     2

`endif

// file: include/cpc_pkg.sv
/*
  Types shared by the capture/compare unit. Assumes cpc_defines.svh.
*/
package cpc_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cpc_bus_req_t;

  typedef enum logic [2:0] {
    CPC_CLS_OFF = 3'b001,
    CPC_CLS_CAP = 3'b010,
    CPC_CLS_CMP = 3'b100
  } cpc_class_t;
endpackage

// file: verilog/cpc_timer.sv
/*
  Sixteen-bit count with a tick enable, a load port and a deferred reset.
  Assumes ticks and the sleep level come from logic on clk.
*/
module cpc_timer #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             tick,
  input  wire logic             run,
  input  wire logic             hold,
  input  wire logic             load_lo,
  input  wire logic             load_hi,
  input  wire logic [7:0]       load_data,
  input  wire logic             reset_arm,
  input  wire logic             reset_keep,
  // Count
  output logic      [WIDTH-1:0] count_q
);
  logic pend_q;

  // Reset waits for the next timer tick and is dropped if the match goes away
  always_ff @(posedge clk) begin
    if (!rst_n || !reset_keep) begin
      pend_q <= 1'b0;
    end else if (reset_arm) begin
      pend_q <= 1'b1;
    end else if (tick) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (load_lo) begin
      count_q[7:0] <= load_data;
    end else if (load_hi) begin
      count_q[WIDTH-1:8] <= load_data[WIDTH-9:0];
    end else if (tick && run && !hold) begin
      // A tick in the trigger cycle already is the next timer edge
      if ((pend_q || reset_arm) && reset_keep) begin
        count_q <= '0;
      end else begin
        count_q <= count_q + 1'b1;
      end
    end
  end
endmodule // cpc_timer

// file: verilog/cpc_unit.sv
/*
  Capture/compare unit: edge prescaler, capture into the value pair,
  compare against the timer, special event trigger and interrupt.
  Assumes a one-cycle timer tick enable, an asynchronous pin input
  and a simple strobed register port on clk.
*/
// Summary of operation
// - Prescaler clears when unit is off or not in a capture mode.
// - Every reset zeroes the prescaler counter.
// - Changing prescale directly keeps the count; software clears control first.
// - Instruction-clock timer holds its count in sleep and resumes after.
// - Capture still works in sleep with an external timer clock.
// - Compare mode checks the value pair against the timer continuously.
// - A match sets, clears or toggles the pin, triggers, or interrupts only.
// - Every compare match also sets the interrupt flag.
// - Writing zero to control drives the compare latch low.
// - Mode 1010 only raises the flag and leaves the pin alone.
// - Mode 1011 resets the timer and starts an ADC conversion.
// - Trigger is immediate; timer clear waits for the next timer tick.
// - Removing the match before that tick skips the timer reset.
// - A selected capture edge copies the timer into the value pair.
// - A new capture overwrites an unread value.
`include "cpc_defines.svh"

module cpc_unit #(
  parameter int PRESCALE_W = 4
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Register port
  input  wire cpc_pkg::cpc_bus_req_t bus_req,
  output logic              [7:0] rdata_q,
  // Timer time base and sleep
  input  wire logic               tick_int,
  input  wire logic               tick_ext,
  input  wire logic               sleep,
  // Pin
  input  wire logic               pin_in,
  output logic                    pin_out_q,
  output logic                    pin_oe_q,
  // Events
  output logic                    adc_start_q,
  output logic                    irq_q
);
  import cpc_pkg::*;

  logic [7:0]  control_q;
  logic [15:0] value_q;
  logic [1:0]  status_q;
  logic [1:0]  mask_q;
  logic [2:0]  tcfg_q;
  logic [PRESCALE_W-1:0] pre_q;
  logic        sync1_q;
  logic        sync2_q;
  logic        pin_prev_q;
  logic        match_prev_q;
  logic        latch_q;
  logic [15:0] count;
  logic [3:0]  mode;
  cpc_class_t  cls;
  logic        tick;
  logic        hold;
  logic        rise;
  logic        fall;
  logic        cap_evt;
  logic        match;
  logic        match_evt;
  logic        trig_evt;
  logic        ctl_wr;
  logic        wr_lo;
  logic        wr_hi;

  assign mode   = control_q[`CPC_MODE_MSB:`CPC_MODE_LSB];
  assign ctl_wr = bus_req.wr && bus_req.addr == `CPC_ADDR_CONTROL;
  assign wr_lo  = bus_req.wr && bus_req.addr == `CPC_ADDR_VALUE_LO;
  assign wr_hi  = bus_req.wr && bus_req.addr == `CPC_ADDR_VALUE_HI;

  always_comb begin
    case (mode)
      `CPC_MODE_CAP_FALL, `CPC_MODE_CAP_RISE,
      `CPC_MODE_CAP_RISE4, `CPC_MODE_CAP_RISE16: cls = CPC_CLS_CAP;
      `CPC_MODE_CMP_SET, `CPC_MODE_CMP_CLR, `CPC_MODE_CMP_TOG,
      `CPC_MODE_CMP_SWI, `CPC_MODE_CMP_SPEC:    cls = CPC_CLS_CMP;
      default:                                  cls = CPC_CLS_OFF;
    endcase
  end

  // Only an external clock keeps ticking in sleep; system clock here stays alive
  assign tick = tcfg_q[`CPC_TCFG_EXT] ? tick_ext : tick_int;
  assign hold = sleep && !tcfg_q[`CPC_TCFG_EXT];

  cpc_timer #(
    .WIDTH(16)
  ) u_timer (
    .clk        (clk),
    .rst_n      (rst_n),
    .tick       (tick),
    .run        (tcfg_q[`CPC_TCFG_RUN]),
    .hold       (hold),
    .load_lo    (bus_req.wr && bus_req.addr == `CPC_ADDR_COUNT_LO),
    .load_hi    (bus_req.wr && bus_req.addr == `CPC_ADDR_COUNT_HI),
    .load_data  (bus_req.wdata),
    .reset_arm  (trig_evt),
    .reset_keep (match && cls == CPC_CLS_CMP && mode == `CPC_MODE_CMP_SPEC),
    .count_q    (count)
  );

  // Pin synchroniser; only the second stage feeds edge logic
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_q    <= 1'b0;
      sync2_q    <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      sync1_q    <= pin_in;
      sync2_q    <= sync1_q;
      pin_prev_q <= sync2_q;
    end
  end

  assign rise = sync2_q && !pin_prev_q;
  assign fall = !sync2_q && pin_prev_q;

  // Prescaler; a direct prescale change keeps the count, so a stray event can follow
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_q <= '0;
    end else if (cls != CPC_CLS_CAP) begin
      pre_q <= '0;
    end else if (rise && mode != `CPC_MODE_CAP_FALL) begin
      pre_q <= pre_q + 1'b1;
    end
  end

  always_comb begin
    cap_evt = 1'b0;
    if (cls == CPC_CLS_CAP) begin
      case (mode)
        `CPC_MODE_CAP_FALL:   cap_evt = fall;
        `CPC_MODE_CAP_RISE:   cap_evt = rise;
        `CPC_MODE_CAP_RISE4:  cap_evt = rise && pre_q[1:0] == 2'h3;
        `CPC_MODE_CAP_RISE16: cap_evt = rise && pre_q[3:0] == 4'hf;
        default:              cap_evt = 1'b0;
      endcase
    end
  end

  assign match     = count == value_q;
  assign match_evt = cls == CPC_CLS_CMP && match && !match_prev_q;
  assign trig_evt  = match_evt && mode == `CPC_MODE_CMP_SPEC;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      match_prev_q <= 1'b0;
    end else begin
      match_prev_q <= match && cls == CPC_CLS_CMP;
    end
  end

  // Value pair: capture overwrites whatever software has not yet read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      value_q <= '0;
    end else if (cap_evt) begin
      value_q <= count;
    end else if (wr_lo) begin
      value_q[7:0] <= bus_req.wdata;
    end else if (wr_hi) begin
      value_q[15:8] <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      control_q <= `CPC_CONTROL_RST;
      mask_q    <= '0;
      tcfg_q    <= '0;
    end else if (bus_req.wr) begin
      case (bus_req.addr)
        `CPC_ADDR_CONTROL:   control_q <= bus_req.wdata;
        `CPC_ADDR_MASK:      mask_q    <= bus_req.wdata[1:0];
        `CPC_ADDR_TIMER_CFG: tcfg_q    <= bus_req.wdata[2:0];
        default:             control_q <= control_q;
      endcase
    end
  end

  // Compare output latch and pin ownership
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latch_q <= 1'b0;
    end else if (ctl_wr && bus_req.wdata == 8'h00) begin
      latch_q <= 1'b0;
    end else if (match_evt) begin
      case (mode)
        `CPC_MODE_CMP_SET: latch_q <= 1'b1;
        `CPC_MODE_CMP_CLR: latch_q <= 1'b0;
        `CPC_MODE_CMP_TOG: latch_q <= !latch_q;
        default:           latch_q <= latch_q;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_out_q <= 1'b0;
      pin_oe_q  <= 1'b0;
    end else begin
      pin_out_q <= latch_q;
      pin_oe_q  <= mode == `CPC_MODE_CMP_SET || mode == `CPC_MODE_CMP_CLR ||
                   mode == `CPC_MODE_CMP_TOG;
    end
  end

  // Trigger leaves one cycle after the match is seen
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      adc_start_q <= 1'b0;
    end else begin
      adc_start_q <= trig_evt && tcfg_q[`CPC_TCFG_ADC_EN];
    end
  end

  // Status: set wins over write-one-to-clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_q <= '0;
    end else begin
      status_q[`CPC_ST_EVENT] <= (status_q[`CPC_ST_EVENT] &&
        !(bus_req.wr && bus_req.addr == `CPC_ADDR_STATUS && bus_req.wdata[0]))
        || cap_evt || match_evt;
      status_q[`CPC_ST_TRIG] <= (status_q[`CPC_ST_TRIG] &&
        !(bus_req.wr && bus_req.addr == `CPC_ADDR_STATUS && bus_req.wdata[1]))
        || trig_evt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        `CPC_ADDR_CONTROL:   rdata_q <= control_q;
        `CPC_ADDR_VALUE_LO:  rdata_q <= value_q[7:0];
        `CPC_ADDR_VALUE_HI:  rdata_q <= value_q[15:8];
        `CPC_ADDR_STATUS:    rdata_q <= {6'h00, status_q};
        `CPC_ADDR_MASK:      rdata_q <= {6'h00, mask_q};
        `CPC_ADDR_TIMER_CFG: rdata_q <= {5'h00, tcfg_q};
        `CPC_ADDR_COUNT_LO:  rdata_q <= count[7:0];
        `CPC_ADDR_COUNT_HI:  rdata_q <= count[15:8];
        default:             rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
endmodule // cpc_unit

// file: dv/cpc_checker.sv
/* Port assertions for cpc_unit.
   Assumes a bind from the bench top and the documented mode codes. */
module cpc_checker (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rst_n,
  // Watched ports
  input wire cpc_pkg::cpc_bus_req_t bus_req,
  input wire logic [7:0]            rdata_q,
  input wire logic                  pin_out_q,
  input wire logic                  pin_oe_q,
  input wire logic                  adc_start_q,
  input wire logic                  irq_q
);
  timeunit 1ns;
  timeprecision 1ns;
  import cpc_pkg::*;
  logic [3:0] mode_q;
  logic [7:0] mask_q;
  logic       adc_en_q;
  // Shadows of control, mask and config writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q   <= 4'h0;
      mask_q   <= 8'h00;
      adc_en_q <= 1'b0;
    end else if (bus_req.wr) begin
      if (bus_req.addr == 4'h0) mode_q <= bus_req.wdata[3:0];
      if (bus_req.addr == 4'h4) mask_q <= {6'h00, bus_req.wdata[1:0]};
      if (bus_req.addr == 4'h5) adc_en_q <= bus_req.wdata[2];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata_q == 8'h00)
    else $error("read data not zero without a read");
  a_unmapped_zero: assert property ($past(bus_req.rd && bus_req.addr > 4'h7) |-> rdata_q == 8'h00)
    else $error("unmapped read not zero");
  a_adc_pulse: assert property (adc_start_q |=> !adc_start_q)
    else $error("conversion start longer than one cycle");
  a_adc_mode: assert property (adc_start_q |-> $past(mode_q) == 4'hb && $past(adc_en_q))
    else $error("conversion start outside trigger mode");
  a_zero_ctrl: assert property (bus_req.wr && bus_req.addr == 4'h0 && bus_req.wdata == 8'h00
    |-> ##[1:3] (!pin_out_q && !pin_oe_q))
    else $error("output latch not low after control cleared");
  a_oe_mode: assert property (pin_oe_q |-> $past(mode_q) inside {4'h2, 4'h8, 4'h9})
    else $error("pin driven outside pin modes");
  a_pin_rise: assert property ($rose(pin_out_q) |-> $past(mode_q, 2) inside {4'h2, 4'h8})
    else $error("pin rose in a mode that cannot set it");
  a_mask_gate: assert property (mask_q == 8'h00 |=> !irq_q)
    else $error("interrupt with all sources masked");
  c_adc: cover property (adc_start_q);
  c_pin: cover property ($rose(pin_out_q));
  c_irq: cover property ($rose(irq_q));
endmodule // cpc_checker

// file: dv/cpc_far_end.sv
/* Far side of the unit: timer tick sources and the pin.
   Assumes the bench sets the enables and the pin level. */
module cpc_far_end #(
  parameter int DIV = 2
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Bench control
  input  wire logic int_en,
  input  wire logic ext_en,
  input  wire logic pin_lvl,
  // Towards the unit
  output logic      tick_int = 1'b0,
  output logic      tick_ext = 1'b0,
  output logic      pin_in = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  // Ticks stay synchronous, never the raw clock: a faster source would break capture
  always @(posedge clk) begin
    cnt <= (!rst_n || cnt == DIV - 1) ? 0 : cnt + 1;
    tick_int <= rst_n && int_en && cnt == 0;
    tick_ext <= rst_n && ext_en && cnt == DIV - 1;
  end
  // Pin edges land off the clock edge, as from a real board
  always @(pin_lvl) pin_in <= #7 pin_lvl;
endmodule // cpc_far_end

// file: dv/cpc_unit_test.sv
/* Self-checking bench for cpc_unit.
   Assumes the package, checker and far-end model are compiled first. */
module cpc_unit_test;
  timeunit 1ns;
  timeprecision 1ns;
  import cpc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, sleep = 1'b0;
  logic int_en = 1'b0, ext_en = 1'b0, pin_lvl = 1'b0;
  cpc_bus_req_t req = '0;
  logic [7:0] rdata_q, d;
  logic tick_int, tick_ext, pin_in, pin_out_q, pin_oe_q, adc_start_q, irq_q;
  logic [15:0] t, v;
  int fails = 0, total_checks = 0, adc_cnt = 0, n;
  logic [3:0] cm [5] = '{4'h8, 4'h9, 4'h2, 4'ha, 4'hb};
  logic [3:0] zr [6] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h9, 4'hf};
  cpc_unit cpc_unit_inst (.clk(clk), .rst_n(rst_n), .bus_req(req), .rdata_q(rdata_q),
    .tick_int(tick_int), .tick_ext(tick_ext), .sleep(sleep), .pin_in(pin_in),
    .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q), .adc_start_q(adc_start_q), .irq_q(irq_q));
  cpc_far_end #(.DIV(2)) cpc_far_end_inst (.clk(clk), .rst_n(rst_n), .int_en(int_en),
    .ext_en(ext_en), .pin_lvl(pin_lvl), .tick_int(tick_int), .tick_ext(tick_ext),
    .pin_in(pin_in));
  initial forever #20 clk = ~clk;
  always @(negedge clk) if (adc_start_q) adc_cnt++;
  function automatic logic exp_pin(input logic [3:0] m);
    return m == 4'h8 || m == 4'h2;
  endfunction
  function automatic logic exp_oe(input logic [3:0] m);
    return m inside {4'h2, 4'h8, 4'h9};
  endfunction
  task automatic chk(input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] w);
    @(posedge clk) req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
    @(posedge clk) req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] r);
    @(posedge clk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) req.rd <= 1'b0;
    #1 r = rdata_q;
  endtask
  task automatic rd16(input logic [3:0] a, output logic [15:0] r);
    rd(a, r[7:0]);
    rd(a + 4'h1, r[15:8]);
  endtask
  task automatic tog(input int k);
    repeat (k) begin
      @(posedge clk) pin_lvl <= !pin_lvl;
      repeat (6) @(posedge clk);
    end
  endtask
  task automatic final_report;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #800000;
    fails++;
    final_report();
  end
  initial begin
    void'($urandom(13));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    foreach (zr[i]) begin
      rd(zr[i], d);
      chk(d, 8'h00);
    end
    $display("reset done");
    wr(4'h4, 8'h01);
    for (int m = 4; m < 6; m++) begin
      wr(4'h0, 8'(m));
      repeat (2) begin
        t = 16'($urandom);
        wr(4'h6, ~t[7:0]);
        wr(4'h7, ~t[15:8]);
        tog(2);
        wr(4'h6, t[7:0]);
        wr(4'h7, t[15:8]);
        tog(2);
        rd16(4'h1, v);
        chk(v, t);
      end
      chk(irq_q, 1'b1);
      wr(4'h4, 8'h00);
      @(posedge clk);
      #1 chk(irq_q, 1'b0);
      wr(4'h4, 8'h01);
      wr(4'h3, 8'h01);
      rd(4'h3, d);
      chk(d, 8'h00);
    end
    for (int m = 6; m < 8; m++) begin
      n = (m == 6) ? 4 : 16;
      wr(4'h0, 8'(m));
      tog(2);
      if (m == 6) wr(4'h0, 8'h00);
      else begin
        @(posedge clk) rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
      end
      wr(4'h0, 8'(m));
      wr(4'h3, 8'h01);
      tog(2 * n - 2);
      rd(4'h3, d);
      chk(d[0], 1'b0);
      tog(2);
      rd(4'h3, d);
      chk(d[0], 1'b1);
    end
    $display("capture done");
    t = {2'b01, 14'($urandom)};
    wr(4'h6, t[7:0]);
    wr(4'h7, t[15:8]);
    sleep <= 1'b1;
    int_en <= 1'b1;
    wr(4'h5, 8'h01);
    repeat (20) @(posedge clk);
    rd16(4'h6, v);
    chk(v, t);
    sleep <= 1'b0;
    repeat (20) @(posedge clk);
    wr(4'h5, 8'h00);
    rd16(4'h6, v);
    chk(v > t && v < t + 16'd64, 1'b1);
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h05);
    wr(4'h3, 8'h01);
    sleep <= 1'b1;
    ext_en <= 1'b1;
    wr(4'h5, 8'h03);
    tog(2);
    rd(4'h3, d);
    chk(d[0], 1'b1);
    sleep <= 1'b0;
    $display("sleep done");
    wr(4'h4, 8'h01);
    foreach (cm[i]) begin
      wr(4'h5, 8'h00);
      if (cm[i] != 4'h9) begin
        wr(4'h0, 8'h00);
        @(posedge clk);
        #1 chk(pin_out_q, 1'b0);
      end
      t = {2'b01, 14'($urandom)};
      v = t + 16'd20;
      wr(4'h6, t[7:0]);
      wr(4'h7, t[15:8]);
      wr(4'h1, v[7:0]);
      wr(4'h2, v[15:8]);
      wr(4'h3, 8'h01);
      adc_cnt = 0;
      wr(4'h0, {4'h0, cm[i]});
      wr(4'h5, 8'h05);
      repeat (80) @(posedge clk);
      chk(pin_out_q, exp_pin(cm[i]));
      chk(pin_oe_q, exp_oe(cm[i]));
      chk(irq_q, 1'b1);
      chk(adc_cnt == 1, cm[i] == 4'hb);
      wr(4'h5, 8'h00);
      rd16(4'h6, v);
      chk(v < 16'd64, cm[i] == 4'hb);
    end
    $display("compare done");
    wr(4'h5, 8'h00);
    wr(4'h0, 8'h00);
    ext_en <= 1'b0;
    wr(4'h6, t[7:0]);
    wr(4'h7, t[15:8]);
    wr(4'h1, ~t[7:0]);
    wr(4'h2, t[15:8]);
    wr(4'h3, 8'h03);
    wr(4'h0, 8'h0b);
    wr(4'h5, 8'h07);
    adc_cnt = 0;
    wr(4'h1, t[7:0]);
    wr(4'h1, ~t[7:0]);
    ext_en <= 1'b1;
    repeat (20) @(posedge clk);
    wr(4'h5, 8'h00);
    rd16(4'h6, v);
    chk(v > t, 1'b1);
    chk(adc_cnt == 1, 1'b1);
    rd(4'h3, d);
    chk(d[1:0], 2'h3);
    $display("trigger skip done");
    final_report();
  end
endmodule // cpc_unit_test
bind cpc_unit cpc_checker cpc_checker_inst (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
  .rdata_q(rdata_q), .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q),
  .adc_start_q(adc_start_q), .irq_q(irq_q));
